// ==== phdma_map.vh ====
`ifndef PHDMA_MAP_VH
`define PHDMA_MAP_VH

// ---------------------------------------------
// Register byte offsets, then the paddr[11:8] and paddr[11] region select values
// ---------------------------------------------
`define PHD_A_CTRL   12'h000
`define PHD_A_TRIG   12'h004
`define PHD_A_STALL  12'h008
`define PHD_A_CXL    12'h00C
`define PHD_A_ACT    12'h010
`define PHD_A_STAT   12'h014
`define PHD_A_CHCFG  4'h1
`define PHD_A_TD     1'b1

// ---------------------------------------------
// Sizes and counts
// ---------------------------------------------
`define PHD_NCH      24
`define PHD_NTD      127
`define PHD_NTDW     508
`define PHD_NSPK     8
`define PHD_STARVE   8'h10
`define PHD_FULLCNT  17'h10000

// ---------------------------------------------
// Channel config fields
// ---------------------------------------------
`define PHD_C_PRIO   2:0
`define PHD_C_RRD    3
`define PHD_C_FIRST  10:4
`define PHD_C_TSRC   15:11
`define PHD_C_TCH    16
`define PHD_C_DRQ    17
`define PHD_CFG_RST  18'h00000

// ---------------------------------------------
// Descriptor word 2 and word 3 fields
// ---------------------------------------------
`define PHD_W2_CNT   15:0
`define PHD_W2_UNB   16
`define PHD_W2_IRQ0  17
`define PHD_W2_IRQ1  18
`define PHD_W2_WID   20:19
`define PHD_W2_BLEN  27:21
`define PHD_W3_NEXT  6:0
`define PHD_W3_CHAIN 7

`endif

// ==== phdma_arb.v ====
module phdma_arb #(
	parameter NCH = 24
) (
	input  wire             pclk,
	input  wire             presetn,
	input  wire             ce,
	input  wire [NCH-1:0]   req,
	input  wire [3*NCH-1:0] prio,
	input  wire [NCH-1:0]   rrd,
	input  wire             fair,
	input  wire             take,
	output reg              gv,
	output reg  [4:0]       gch
);
	reg  [5:0]     slot_r;
	reg  [4:0]     last_r;
	reg  [2:0]     lvl;
	reg  [2:0]     fav;
	reg  [7:0]     has;
	reg  [NCH-1:0] m;
	reg            hv;
	integer        i;
	integer        j;
	integer        sel;
	integer        hsel;
	wire [8*NCH-1:0] loh;

// ---------------------------------------------
// Per-channel level decode
// ---------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NCH; g = g + 1) begin : lv
			assign loh[g*8 +: 8] = req[g] ? (8'h01 << prio[g*3 +: 3]) : 8'h00;
		end
	endgenerate

// ---------------------------------------------
// Winner selection
// ---------------------------------------------
	always @* begin
		has = 8'h00;
		for (i = 0; i < NCH; i = i + 1)
			has = has | loh[i*8 +: 8];
		if (slot_r[0])
			fav = 3'h2;
		else if (slot_r[1])
			fav = 3'h3;
		else if (slot_r[2])
			fav = 3'h4;
		else if (slot_r[3])
			fav = 3'h5;
		else if (slot_r[4])
			fav = 3'h6;
		else
			fav = 3'h7;
		lvl = 3'h7;
		for (i = 7; i >= 0; i = i - 1)
			if (has[i])
				lvl = i[2:0];
		if (fair && !has[0] && !has[1] && has[fav])
			lvl = fav;
		for (i = 0; i < NCH; i = i + 1)
			m[i] = loh[i*8 + lvl];
		hv = 1'b0;
		hsel = 0;
		for (i = NCH - 1; i >= 0; i = i - 1)
			if (m[i] && rrd[i]) begin
				hv = 1'b1;
				hsel = i;
			end
		sel = 0;
		for (i = NCH; i >= 1; i = i - 1) begin
			j = last_r + i;
			if (j >= NCH)
				j = j - NCH;
			if (m[j])
				sel = j;
		end
		if (hv)
			sel = hsel;
		gv = |has;
		gch = sel[4:0];
	end

// ---------------------------------------------
// Round-robin pointer and fairness slot
// ---------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slot_r <= 6'h01;
			last_r <= 5'h00;
		end else if (ce && take) begin
			last_r <= gch;
			if (lvl > 3'h1)
				slot_r <= slot_r + 6'h01;
		end
	end
endmodule

// ==== phdma_top.v ====
// Decided for this implementation: the address map and the APB interface to the registers.
`include "phdma_map.vh"
module phdma_top #(
	parameter         SPK_LSB = 16,
	parameter   [7:0] STARVE  = `PHD_STARVE,
	parameter  [31:0] TD_BASE = 32'h0000_0800
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        ce,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output reg         pslverr,
	input  wire [23:0] drq,
	input  wire [7:0]  cpu_spoke_req,
	output wire [7:0]  cpu_wait,
	output reg         rd_req,
	output reg  [31:0] rd_addr,
	output reg  [1:0]  rd_size,
	input  wire        rd_ack,
	input  wire [31:0] rd_data,
	output reg         wr_req,
	output reg  [31:0] wr_addr,
	output reg  [1:0]  wr_size,
	output reg  [31:0] wr_data,
	input  wire        wr_ack,
	output reg  [23:0] irq0,
	output reg  [23:0] irq1
);
	localparam E_IDLE = 2'h0;
	localparam E_RUN  = 2'h1;
	localparam E_END  = 2'h2;

	reg  [31:0] td_mem [0:`PHD_NTDW-1];
	reg  [31:0] ch_src [0:`PHD_NCH-1];
	reg  [31:0] ch_dst [0:`PHD_NCH-1];
	reg  [16:0] ch_cnt [0:`PHD_NCH-1];
	reg  [6:0]  ch_td  [0:`PHD_NCH-1];
	reg  [17:0] cfg    [0:`PHD_NCH-1];
	reg  [23:0] drq_m;
	reg  [23:0] drq_s;
	reg  [23:0] drq_d;
	reg         fair_r;
	reg  [23:0] stall_r;
	reg  [23:0] act_r;
	reg  [23:0] cxl_r;
	reg  [23:0] done_r;
	reg  [1:0]  st_r;
	reg  [4:0]  cur_r;
	reg  [31:0] e_src;
	reg  [31:0] e_dst;
	reg  [16:0] e_cnt;
	reg  [6:0]  e_bl;
	reg         e_unb;
	reg  [1:0]  e_wid;
	reg  [31:0] q0d;
	reg  [31:0] q1d;
	reg  [1:0]  q0s;
	reg  [1:0]  q1s;
	reg  [1:0]  qn;
	reg  [7:0]  stv_r;
	reg  [31:0] rmux;
	reg  [23:0] trg_ch;
	integer     i;
	integer     si;
	integer     ri;

// ---------------------------------------------
// APB decode
// ---------------------------------------------
	wire        setup  = psel & ~penable;
	wire        wr_en  = psel & penable & pready & pwrite;
	wire        is_cfg = (paddr[11:8] == `PHD_A_CHCFG) && (paddr[7:2] < 6'd24);
	wire        is_td  = (paddr[11] == `PHD_A_TD) && (paddr[10:2] < 9'd508);
	wire        is_reg = (paddr[11:5] == 7'h00) && (paddr[4:2] < 3'h6);
	wire [23:0] trg_w  = (wr_en && paddr == `PHD_A_TRIG) ? pwdata[23:0] : 24'h000000;
	wire [23:0] cxl_w  = (wr_en && paddr == `PHD_A_CXL) ? pwdata[23:0] : 24'h000000;

// ---------------------------------------------
// Engine datapath terms
// ---------------------------------------------
	wire [31:0] w2     = td_mem[{ch_td[cur_r], 2'b10}];
	wire [31:0] w3     = td_mem[{ch_td[cur_r], 2'b11}];
	wire        done_d = !e_unb && (e_cnt == 17'h00000);
	wire [2:0]  ss     = e_src[SPK_LSB+2:SPK_LSB];
	wire [2:0]  ds     = e_dst[SPK_LSB+2:SPK_LSB];
	wire        sdiff  = ss != ds;
	wire        int_hit = e_dst[31:11] == TD_BASE[31:11];
	wire [2:0]  bsz    = {1'b0, e_wid} + 3'h1;
	wire [2:0]  nb1    = ({4'h0, bsz} > e_bl) ? e_bl[2:0] : bsz;
	wire [2:0]  nb     = (!e_unb && {14'h0000, nb1} > e_cnt) ? e_cnt[2:0] : nb1;
	wire [1:0]  occ    = qn + {1'b0, rd_req};
	wire        run    = st_r == E_RUN;
	wire        want_rd = run && !rd_req && e_bl != 7'h00 && !done_d
		&& (occ == 2'h0 || (occ == 2'h1 && sdiff));
	wire        want_wr = run && qn != 2'h0 && !wr_req && !int_hit;
	wire        stv_hit = stv_r >= STARVE;
	wire        rd_go  = want_rd && (!cpu_spoke_req[ss] || stv_hit);
	wire        wr_go  = want_wr && (!cpu_spoke_req[ds] || stv_hit);
	wire        int_we = run && qn != 2'h0 && !wr_req && int_hit;
	wire        push   = rd_req & rd_ack;
	wire        pop    = (wr_req & wr_ack) | int_we;
	wire        b_end  = run && !rd_req && !wr_req && qn == 2'h0
		&& (e_bl == 7'h00 || done_d);
	wire        in_end = st_r == E_END;
	wire        e_cxl  = cxl_r[cur_r] | cxl_w[cur_r];
	wire        nxt_go = in_end && done_d && w3[`PHD_W3_CHAIN] && !e_cxl;
	wire [6:0]  nxt    = w3[`PHD_W3_NEXT];
	wire [23:0] run_m  = (st_r != E_IDLE) ? (24'h000001 << cur_r) : 24'h000000;
	wire [23:0] end_m  = in_end ? (24'h000001 << cur_r) : 24'h000000;
	wire [23:0] end_clr = (in_end && (e_cxl || (done_d && !nxt_go))) ? end_m : 24'h000000;
	wire [23:0] drq_en;
	wire [23:0] trg_ok = (trg_w | trg_ch | (drq_s & ~drq_d & drq_en)) & ~act_r;
	wire [71:0] pr_flat;
	wire [23:0] rrd;
	wire        gv;
	wire [4:0]  gch;
	wire        take   = (st_r == E_IDLE) && gv;

	assign pready = ce & ~(is_td & pwrite & int_we);

	function [16:0] cntof;
		input [15:0] f;
		begin
			cntof = (f == 16'h0000) ? `PHD_FULLCNT : {1'b0, f};
		end
	endfunction

// ---------------------------------------------
// Per-channel and per-spoke wiring
// ---------------------------------------------
	genvar g;
	generate
		for (g = 0; g < `PHD_NCH; g = g + 1) begin : chw
			assign pr_flat[g*3 +: 3] = cfg[g][`PHD_C_PRIO];
			assign rrd[g]            = cfg[g][`PHD_C_RRD];
			assign drq_en[g]         = cfg[g][`PHD_C_DRQ];
		end
		for (g = 0; g < `PHD_NSPK; g = g + 1) begin : spw
			assign cpu_wait[g] = stv_hit && ((want_rd && ss == g) || (want_wr && ds == g));
		end
	endgenerate

	always @* begin
		for (i = 0; i < `PHD_NCH; i = i + 1)
			trg_ch[i] = cfg[i][`PHD_C_TCH] && (cfg[i][`PHD_C_TSRC] < 5'd24)
				&& done_r[cfg[i][`PHD_C_TSRC]];
	end

// ---------------------------------------------
// Arbiter
// ---------------------------------------------
	phdma_arb #(
		.NCH (`PHD_NCH)
	) u_arb (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.req     (act_r & ~stall_r & ~cxl_r),
		.prio    (pr_flat),
		.rrd     (rrd),
		.fair    (fair_r),
		.take    (take),
		.gv      (gv),
		.gch     (gch)
	);

// ---------------------------------------------
// APB read data
// ---------------------------------------------
	always @* begin
		rmux = 32'h0000_0000;
		if (is_td)
			rmux = td_mem[paddr[10:2]];
		else if (is_cfg)
			rmux = {14'h0000, cfg[paddr[6:2]]};
		else case (paddr)
			`PHD_A_CTRL:  rmux = {31'h0000_0000, fair_r};
			`PHD_A_STALL: rmux = {8'h00, stall_r};
			`PHD_A_ACT:   rmux = {8'h00, act_r};
			`PHD_A_STAT:  rmux = {22'h00_0000, st_r, 3'h0, cur_r};
			default:      rmux = 32'h0000_0000;
		endcase
	end

// ---------------------------------------------
// Storage without reset
// ---------------------------------------------
	always @(posedge pclk) begin
		if (ce) begin
			if (int_we)
				td_mem[e_dst[10:2]] <= q0d;
			else if (wr_en && is_td)
				td_mem[paddr[10:2]] <= pwdata;
			for (si = 0; si < `PHD_NCH; si = si + 1)
				if (trg_ok[si]) begin
					ch_td[si]  <= cfg[si][`PHD_C_FIRST];
					ch_src[si] <= td_mem[{cfg[si][`PHD_C_FIRST], 2'b00}];
					ch_dst[si] <= td_mem[{cfg[si][`PHD_C_FIRST], 2'b01}];
					ch_cnt[si] <= cntof(td_mem[{cfg[si][`PHD_C_FIRST], 2'b10}][`PHD_W2_CNT]);
				end
			if (nxt_go) begin
				ch_td[cur_r]  <= nxt;
				ch_src[cur_r] <= td_mem[{nxt, 2'b00}];
				ch_dst[cur_r] <= td_mem[{nxt, 2'b01}];
				ch_cnt[cur_r] <= cntof(td_mem[{nxt, 2'b10}][`PHD_W2_CNT]);
			end else if (in_end && !done_d) begin
				ch_src[cur_r] <= e_src;
				ch_dst[cur_r] <= e_dst;
				ch_cnt[cur_r] <= e_cnt;
			end
		end
	end

// ---------------------------------------------
// Control registers and APB answers
// ---------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drq_m   <= 24'h000000;
			drq_s   <= 24'h000000;
			drq_d   <= 24'h000000;
			fair_r  <= 1'b0;
			stall_r <= 24'h000000;
			act_r   <= 24'h000000;
			cxl_r   <= 24'h000000;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
			for (ri = 0; ri < `PHD_NCH; ri = ri + 1)
				cfg[ri] <= `PHD_CFG_RST;
		end else if (ce) begin
			drq_m <= drq;
			drq_s <= drq_m;
			drq_d <= drq_s;
			if (setup) begin
				prdata  <= rmux;
				pslverr <= !(is_td || is_cfg || is_reg);
			end
			if (wr_en && paddr == `PHD_A_CTRL)
				fair_r <= pwdata[0];
			if (wr_en && paddr == `PHD_A_STALL)
				stall_r <= pwdata[23:0];
			if (wr_en && is_cfg)
				cfg[paddr[6:2]] <= pwdata[17:0];
			act_r <= (act_r | trg_ok) & ~(cxl_w & ~run_m) & ~end_clr;
			cxl_r <= (cxl_r | (cxl_w & run_m)) & ~end_m;
		end
	end

// ---------------------------------------------
// Transfer engine
// ---------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r    <= E_IDLE;
			cur_r   <= 5'h00;
			e_src   <= 32'h0000_0000;
			e_dst   <= 32'h0000_0000;
			e_cnt   <= 17'h00000;
			e_bl    <= 7'h00;
			e_unb   <= 1'b0;
			e_wid   <= 2'h0;
			rd_req  <= 1'b0;
			rd_addr <= 32'h0000_0000;
			rd_size <= 2'h0;
			wr_req  <= 1'b0;
			wr_addr <= 32'h0000_0000;
			wr_size <= 2'h0;
			wr_data <= 32'h0000_0000;
			q0d     <= 32'h0000_0000;
			q1d     <= 32'h0000_0000;
			q0s     <= 2'h0;
			q1s     <= 2'h0;
			qn      <= 2'h0;
			stv_r   <= 8'h00;
			irq0    <= 24'h000000;
			irq1    <= 24'h000000;
			done_r  <= 24'h000000;
		end else if (ce) begin
			irq0   <= 24'h000000;
			irq1   <= 24'h000000;
			done_r <= 24'h000000;
			if ((want_rd && !rd_go) || (want_wr && !wr_go))
				stv_r <= stv_r + 8'h01;
			else
				stv_r <= 8'h00;
			if (push)
				rd_req <= 1'b0;
			if (wr_req && wr_ack)
				wr_req <= 1'b0;
			if (rd_go) begin
				rd_req  <= 1'b1;
				rd_addr <= e_src;
				rd_size <= nb[1:0] - 2'h1;
				e_src   <= e_src + {29'h0, nb};
				e_bl    <= e_bl - {4'h0, nb};
				if (!e_unb)
					e_cnt <= e_cnt - {14'h0000, nb};
			end
			if (wr_go || int_we) begin
				wr_req  <= wr_go;
				wr_addr <= e_dst;
				wr_size <= q0s;
				wr_data <= q0d;
				e_dst   <= e_dst + {30'h0, q0s} + 32'h1;
			end
			case ({push, pop})
				2'b10: begin
					if (qn == 2'h0) begin
						q0d <= rd_data;
						q0s <= rd_size;
					end else begin
						q1d <= rd_data;
						q1s <= rd_size;
					end
					qn <= qn + 2'h1;
				end
				2'b01: begin
					q0d <= q1d;
					q0s <= q1s;
					qn  <= qn - 2'h1;
				end
				2'b11: begin
					if (qn == 2'h1) begin
						q0d <= rd_data;
						q0s <= rd_size;
					end else begin
						q0d <= q1d;
						q0s <= q1s;
						q1d <= rd_data;
						q1s <= rd_size;
					end
				end
				default: qn <= qn;
			endcase
			case (st_r)
				E_IDLE: begin
					if (gv) begin
						st_r  <= E_RUN;
						cur_r <= gch;
						e_src <= ch_src[gch];
						e_dst <= ch_dst[gch];
						e_cnt <= ch_cnt[gch];
						e_unb <= td_mem[{ch_td[gch], 2'b10}][`PHD_W2_UNB];
						e_wid <= td_mem[{ch_td[gch], 2'b10}][`PHD_W2_WID];
						e_bl  <= (td_mem[{ch_td[gch], 2'b10}][`PHD_W2_BLEN] == 7'h00) ? 7'h01
							: td_mem[{ch_td[gch], 2'b10}][`PHD_W2_BLEN];
					end
				end
				E_RUN: begin
					if (b_end)
						st_r <= E_END;
				end
				E_END: begin
					st_r <= E_IDLE;
					if (done_d && w2[`PHD_W2_IRQ0])
						irq0[cur_r] <= 1'b1;
					if (done_d && !nxt_go && !e_cxl) begin
						done_r[cur_r] <= 1'b1;
						if (w2[`PHD_W2_IRQ1])
							irq1[cur_r] <= 1'b1;
					end
				end
				default: st_r <= E_IDLE;
			endcase
		end
	end
endmodule

// ==== phdma_checker.sv ====
module phdma_checker #(
	parameter        SPK_LSB = 16,
	parameter [31:0] TD_BASE = 32'h0000_0800
) (
	input wire        pclk,
	input wire        presetn,
	input wire        ce,
	input wire        psel,
	input wire        penable,
	input wire [11:0] paddr,
	input wire        pready,
	input wire        pslverr,
	input wire [7:0]  cpu_spoke_req,
	input wire [7:0]  cpu_wait,
	input wire        rd_req,
	input wire [31:0] rd_addr,
	input wire [1:0]  rd_size,
	input wire        rd_ack,
	input wire        wr_req,
	input wire [31:0] wr_addr,
	input wire [1:0]  wr_size,
	input wire [31:0] wr_data,
	input wire        wr_ack,
	input wire [23:0] irq0,
	input wire [23:0] irq1
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] blk_r;
	wire  [2:0] rd_spk = rd_addr[SPK_LSB+2:SPK_LSB];
	wire  [2:0] wr_spk = wr_addr[SPK_LSB+2:SPK_LSB];
	wire        unmap  = (paddr >= 12'h018 && paddr < 12'h100) ||
		(paddr >= 12'h160 && paddr < 12'h800) || paddr >= 12'hFF0;
	// ----------------------------------------
	// Spokes held by the CPU last cycle
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			blk_r <= 8'h00;
		else
			blk_r <= cpu_spoke_req & ~cpu_wait;
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_rd_wait;
		rd_req && !rd_ack;
	endsequence
	sequence s_rd_held;
		rd_req && $stable(rd_addr) && $stable(rd_size);
	endsequence
	sequence s_wr_wait;
		wr_req && !wr_ack;
	endsequence
	sequence s_wr_held;
		wr_req && $stable(wr_addr) && $stable(wr_size) && $stable(wr_data);
	endsequence
	a_rd_hold: assert property (s_rd_wait |=> s_rd_held)
		else $error("read request changed before ack");
	a_wr_hold: assert property (s_wr_wait |=> s_wr_held)
		else $error("write request changed before ack");
	a_cpu_first: assert property ($rose(rd_req) |-> !blk_r[rd_spk])
		else $error("read issued on a spoke the CPU held");
	a_irq0_pulse: assert property (|irq0 |=> (irq0 & $past(irq0)) == 24'h0)
		else $error("irq0 longer than one cycle");
	a_irq1_pulse: assert property (|irq1 |=> (irq1 & $past(irq1)) == 24'h0)
		else $error("irq1 longer than one cycle");
	a_ce_freeze: assert property (!ce |=> $stable({rd_req, wr_req, irq0, irq1}))
		else $error("state moved with clock enable low");
	a_pready_ce: assert property (!ce |-> !pready)
		else $error("ready while clock enable low");
	a_err_map: assert property (psel && !penable && ce |=> pslverr == $past(unmap))
		else $error("error response does not match address map");
	a_spoke_split: assert property (rd_req && wr_req |-> rd_spk != wr_spk)
		else $error("read and write overlap on one spoke");
	a_td_local: assert property (wr_req |-> wr_addr[31:11] != TD_BASE[31:11])
		else $error("descriptor write left on the spoke bus");
endmodule
bind phdma_top phdma_checker #(.SPK_LSB(SPK_LSB), .TD_BASE(TD_BASE)) phdma_checker_inst (
	.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
	.paddr(paddr), .pready(pready), .pslverr(pslverr), .cpu_spoke_req(cpu_spoke_req),
	.cpu_wait(cpu_wait), .rd_req(rd_req), .rd_addr(rd_addr), .rd_size(rd_size),
	.rd_ack(rd_ack), .wr_req(wr_req), .wr_addr(wr_addr), .wr_size(wr_size),
	.wr_data(wr_data), .wr_ack(wr_ack), .irq0(irq0), .irq1(irq1));

// ==== phdma_mem.sv ====
module phdma_mem (
	input  wire         pclk,
	input  wire         presetn,
	input  wire  [3:0]  lat,
	input  wire         rd_req,
	input  wire  [31:0] rd_addr,
	output logic        rd_ack,
	output logic [31:0] rd_data,
	input  wire         wr_req,
	input  wire  [31:0] wr_addr,
	input  wire  [31:0] wr_data,
	output logic        wr_ack
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] wmem [0:63];
	logic [3:0] rcnt_r;
	logic [3:0] wcnt_r;
	wire        rgo = rd_req && !rd_ack && rcnt_r == lat;
	wire        wgo = wr_req && !wr_ack && wcnt_r == lat;
	// ----------------------------------------
	// Spoke slave, answers after lat waits
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_ack  <= 1'b0;
			wr_ack  <= 1'b0;
			rcnt_r  <= 4'h0;
			wcnt_r  <= 4'h0;
			rd_data <= 32'h0;
		end else begin
			rd_ack  <= rgo;
			wr_ack  <= wgo;
			rcnt_r  <= (rd_req && !rd_ack && !rgo) ? rcnt_r + 4'h1 : 4'h0;
			wcnt_r  <= (wr_req && !wr_ack && !wgo) ? wcnt_r + 4'h1 : 4'h0;
			rd_data <= rgo ? ~rd_addr : ~rd_data;
			if (wgo)
				wmem[wr_addr[5:0]] <= wr_data[7:0];
		end
	end
endmodule

// ==== tb.sv ====
`include "phdma_map.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk, presetn, ce, psel, penable, pwrite, e, got;
	logic        pready, pslverr, rd_req, rd_ack, wr_req, wr_ack;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd_addr, rd_data, wr_addr, wr_data, d;
	logic [23:0] drq, irq0, irq1;
	logic [7:0]  cpu_spoke_req, cpu_wait, seen_wait;
	logic [3:0]  lat;
	logic [2:0]  fspk;
	logic [1:0]  rd_size, wr_size, lsz;
	int          err_total, num_checks, wcnt, w0, c, n, ch, ta, tb2, p1, pa;
	int          c0 [24];
	int          c1 [24];
	int          spk_cnt [8];
	phdma_top #(.STARVE(8'h02)) phdma_top_inst (.pclk(pclk), .presetn(presetn), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .drq(drq),
		.cpu_spoke_req(cpu_spoke_req), .cpu_wait(cpu_wait), .rd_req(rd_req),
		.rd_addr(rd_addr), .rd_size(rd_size), .rd_ack(rd_ack), .rd_data(rd_data),
		.wr_req(wr_req), .wr_addr(wr_addr), .wr_size(wr_size), .wr_data(wr_data),
		.wr_ack(wr_ack), .irq0(irq0), .irq1(irq1));
	phdma_mem phdma_mem_inst (.pclk(pclk), .presetn(presetn), .lat(lat), .rd_req(rd_req),
		.rd_addr(rd_addr), .rd_ack(rd_ack), .rd_data(rd_data), .wr_req(wr_req),
		.wr_addr(wr_addr), .wr_data(wr_data), .wr_ack(wr_ack));
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	// ----------------------------------------
	// Event counters
	// ----------------------------------------
	always @(posedge pclk) begin
		for (int i = 0; i < 24; i++) begin
			c0[i] <= c0[i] + irq0[i];
			c1[i] <= c1[i] + irq1[i];
		end
		if (rd_ack) begin
			spk_cnt[rd_addr[18:16]] <= spk_cnt[rd_addr[18:16]] + 1;
			lsz <= rd_size;
		end
		if (wr_ack)
			wcnt <= wcnt + 1;
		seen_wait <= seen_wait | cpu_wait;
		if (rd_req && !got) begin
			got  <= 1'b1;
			fspk <= rd_addr[18:16];
		end
	end
	task automatic finish_test;
		$display("checks=%0d errors=%0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		num_checks++;
		if (s !== x) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		int k;
		k = 0;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		d = prdata;
		e = pslverr;
		if (k >= 50)
			err_total++;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic td(input int t, input logic [31:0] s, x, w2, w3);
		logic [11:0] b;
		b = 12'h800 + (12'(t) << 4);
		apb(1'b1, b, s);
		apb(1'b1, b + 12'h4, x);
		apb(1'b1, b + 12'h8, w2);
		apb(1'b1, b + 12'hC, w3);
	endtask
	task automatic wait_irq(input int h, input int m);
		int k;
		k = 0;
		while (c0[h] < m && k < 4000) begin
			@(posedge pclk);
			k++;
		end
	endtask
	initial begin
		#3_000_000;
		err_total++;
		finish_test();
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, drq, cpu_spoke_req, lat} = '0;
		{ce, got, seen_wait} = {2'b11, 8'h00};
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, `PHD_A_CTRL, 32'h0); chk(d, 32'h0);
		apb(1'b0, `PHD_A_ACT, 32'h0); chk(d, 32'h0);
		apb(1'b0, 12'h114, 32'h0); chk(d, 32'(`PHD_CFG_RST));
		apb(1'b0, 12'h040, 32'h0); chk({d[30:0], e}, 32'h1);
		apb(1'b1, 12'h15C, 32'hFFFF_FFFF); apb(1'b0, 12'h15C, 32'h0);
		chk(d, 32'h0003_FFFF);
		apb(1'b1, 12'h15C, 32'h0);
		apb(1'b1, 12'hFE0, 32'hA5A5_5A5A); apb(1'b0, 12'hFE0, 32'h0);
		chk(d, 32'hA5A5_5A5A);
		ce <= 1'b0;
		repeat (2) @(posedge pclk);
		chk(32'(pready), 32'h0);
		ce <= 1'b1;
		// ----------------------------------------
		// Simple transfer, CPU on a spoke, chain start
		// ----------------------------------------
		td(0, 32'h0001_0010, 32'h0002_0020, 32'h0046_0004, 32'h0);
		td(8, 32'h0003_0040, 32'h0002_0040, 32'h0022_0001, 32'h0);
		apb(1'b1, 12'h100, 32'h0);
		apb(1'b1, 12'h114, 32'h0001_0080);
		for (int k = 0; k < 2; k++) begin
			cpu_spoke_req <= k ? 8'h02 : 8'h20;
			lat <= k ? 4'h3 : 4'h0;
			w0 = wcnt;
			apb(1'b1, `PHD_A_TRIG, 32'h1);
			wait_irq(5, k + 1);
			chk(32'(c0[0]), 32'(k + 1));
			chk(32'(c1[0]), 32'(k + 1));
			chk(32'(c0[5]), 32'(k + 1));
			chk(32'(wcnt - w0), 32'h5);
			for (int i = 0; i < 4; i++)
				chk({24'h0, phdma_mem_inst.wmem[6'h20 + 6'(i)]}, {24'h0, ~(8'h10 + 8'(i))});
			chk({24'h0, seen_wait}, k ? 32'h02 : 32'h00);
		end
		cpu_spoke_req <= 8'h00;
		lat <= 4'h1;
		// ----------------------------------------
		// Priority and round-robin override
		// ----------------------------------------
		td(1, 32'h0003_0000, 32'h0002_0100, 32'h0022_0001, 32'h0);
		td(2, 32'h0004_0000, 32'h0002_0104, 32'h0022_0001, 32'h0);
		for (int r = 0; r < 2; r++) begin
			apb(1'b1, `PHD_A_CTRL, 32'(r));
			apb(1'b1, 12'h104, r ? 32'h0002_001B : 32'h0000_0015);
			apb(1'b1, 12'h108, r ? 32'h0002_0023 : 32'h0000_0021);
			got = 1'b0;
			if (r) begin
				drq <= 24'h000006;
				repeat (4) @(posedge pclk);
				drq <= 24'h000000;
			end else
				apb(1'b1, `PHD_A_TRIG, 32'h6);
			wait_irq(2, r + 1);
			wait_irq(1, r + 1);
			chk(32'(c0[1] + c0[2]), 32'(2 * r + 2));
			chk({29'h0, fspk}, r ? 32'h3 : 32'h4);
		end
		// ----------------------------------------
		// Self-linked and ping-pong chains
		// ----------------------------------------
		for (int r = 0; r < 2; r++) begin
			ch = 3 + r;
			ta = r ? 6 : 5;
			tb2 = r ? 7 : 5;
			td(ta, 32'(ta) << 16, 32'h0000_0100, 32'h011A_0008, 32'h80 | 32'(tb2));
			if (r)
				td(tb2, 32'(tb2) << 16, 32'h0000_0100, 32'h011A_0008, 32'h80 | 32'(ta));
			apb(1'b1, 12'h100 + (12'(ch) << 2), 32'(ta) << 4);
			p1 = spk_cnt[1];
			pa = spk_cnt[ta];
			apb(1'b1, `PHD_A_TRIG, 32'h1 << ch);
			wait_irq(ch, 3);
			chk(32'(spk_cnt[ta] > pa && spk_cnt[tb2] > 0), 32'h1);
			apb(1'b1, 12'h800 + (12'(tb2) << 4), 32'h0001_0000);
			wait_irq(ch, 7);
			chk(32'(spk_cnt[1] > p1), 32'h1);
			chk({30'h0, lsz}, 32'h3);
			apb(1'b1, `PHD_A_STALL, 32'h1 << ch);
			repeat (30) @(posedge pclk);
			c = c0[ch];
			repeat (60) @(posedge pclk);
			chk(32'(c0[ch]), 32'(c));
			apb(1'b1, `PHD_A_STALL, 32'h0);
			wait_irq(ch, c + 1);
			chk(32'(c0[ch] > c), 32'h1);
			apb(1'b1, `PHD_A_CXL, 32'h1 << ch);
			n = 0;
			do begin
				apb(1'b0, `PHD_A_ACT, 32'h0);
				n++;
			end while (d !== 32'h0 && n < 20);
			chk(d, 32'h0);
			c = c0[ch];
			repeat (50) @(posedge pclk);
			chk(32'(c0[ch]), 32'(c));
		end
		finish_test();
	end
endmodule
